// ===== sadc_control.sv
// control logic of a 10-bit successive-approximation converter:
// apb register file, conversion clock, acquisition and conversion
// sequence, result pair and completion flag.
// assumes all inputs are synchronous to pclk; the comparator and
// dac live in the analog front end outside this module.
//
// Design decisions made here: the APB slave port and the register offsets.

`include "sadc_params.svh"

// How it works
// - channel field bits 5-2 drive the mux; codes 13-15 select nothing
// - go bit reads 1 while a conversion runs, 0 when idle
// - converter-on bit enables the converter; clearing it stops it
// - unimplemented control bits ignore writes and read zero
// - bit 5 of control one picks external or ground negative reference
// - bit 4 of control one picks external or supply positive reference
// - codes 0-2 all analog; each step from 3 turns one more digital
// - reset loads pin config 0000 or 0111 from the strap
// - format bit set gives right justification, clear gives left
// - acquisition field maps to 0,2,4,6,8,12,16,20 periods
// - clock field divides by 2..64, codes 011 and 111 use rc clock
// - with rc clock one instruction cycle passes before clock starts
// - reset restores registers, turns off and aborts conversion
// - completion loads result, clears go and sets done flag
// - reset leaves the result pair untouched
// - with rc clock selected conversion runs from the rc ticks only
// - nonzero acquisition time is inserted between go and conversion
// - result comes from successive approximation on the held sample
// - two periods pass after completion before the next acquisition
// - each conversion takes eleven bit-conversion periods
// - after completion sampling of the selected channel resumes
// - zero acquisition time starts conversion at once on go
module sadc_control
  import sadc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic portb_analog_default,
  input wire logic rc_tick,
  input wire logic comparator_high,
  output sadc_analog_s analog_ctl,
  output logic conversion_irq
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // acquisition time in bit-conversion periods
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    logic [4:0] t;
    t = 5'd0;
    unique case (code)
      3'h0: t = 5'd0;
      3'h1: t = 5'd2;
      3'h2: t = 5'd4;
      3'h3: t = 5'd6;
      3'h4: t = 5'd8;
      3'h5: t = 5'd12;
      3'h6: t = 5'd16;
      3'h7: t = 5'd20;
    endcase
    return t;
  endfunction

  // oscillator divider minus one; rc codes return zero
  function automatic logic [5:0] div_last(input logic [2:0] code);
    logic [5:0] d;
    d = 6'h00;
    unique case (code)
      3'h0: d = 6'd1;
      3'h4: d = 6'd3;
      3'h1: d = 6'd7;
      3'h5: d = 6'd15;
      3'h2: d = 6'd31;
      3'h6: d = 6'd63;
      3'h3, 3'h7: d = 6'd0;
    endcase
    return d;
  endfunction

  // analog inputs left for a pin configuration code
  function automatic logic [12:0] analog_pins(input logic [3:0] code);
    logic [3:0] n;
    n = (code < 4'h3) ? 4'h0 : 4'(code - 4'h2);
    return 13'h1fff >> n;
  endfunction

  // apb offset match
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------

  sadc_state_s cur_r;
  sadc_state_s cur_nxt;
  logic [7:0] result_high_r;
  logic [7:0] result_low_r;
  logic res_load;
  logic [15:0] res_word;

  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic rc_sel;
  logic conv_on;
  logic tad_tick;
  logic [9:0] sar_final;
  logic [2:0] cs_code;

  // address decode shared by write and read paths
  assign mapped = hit(paddr, `SADC_OFF_CTL0) ||
                  hit(paddr, `SADC_OFF_CTL1) ||
                  hit(paddr, `SADC_OFF_CTL2) ||
                  hit(paddr, `SADC_OFF_RESH) ||
                  hit(paddr, `SADC_OFF_RESL) ||
                  hit(paddr, `SADC_OFF_IRQ);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // zero wait state slave; error only on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = cur_r.prdata;

  // conversion clock: rc ticks or divided pclk
  assign cs_code = cur_r.ctl2[`SADC_CS_MSB:`SADC_CS_LSB];
  assign rc_sel = cs_code[1] && cs_code[0];
  assign conv_on = cur_r.ctl0[`SADC_ON_BIT];
  assign tad_tick = rc_sel ? rc_tick :
                    (cur_r.divcnt == div_last(cs_code));

  // last comparison folded into the finished code
  assign sar_final = comparator_high ? cur_r.sar :
                     (cur_r.sar & ~(10'h001 << cur_r.bitcnt));

  // justified result image; hi byte first
  assign res_word = cur_r.ctl2[`SADC_FMT_BIT] ?
                    {6'h00, sar_final} :
                    {sar_final, 6'h00};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  always_comb begin
    logic go_wr;
    logic [7:0] wd;
    go_wr = 1'b0;
    wd = pwdata[7:0];
    cur_nxt = cur_r;
    res_load = 1'b0;

    // strap caught on the first edge after reset release
    if (cur_r.strap_pend) begin
      cur_nxt.strap_pend = 1'b0;
      cur_nxt.ctl1[`SADC_PCFG_MSB:`SADC_PCFG_LSB] =
        portb_analog_default ? `SADC_PCFG_STRAP1 :
                               `SADC_PCFG_STRAP0;
    end

    // register writes; unimplemented bits masked off
    if (wr_en) begin
      if (hit(paddr, `SADC_OFF_CTL0)) begin
        cur_nxt.ctl0 = (wd & `SADC_MASK_CTL0) & ~8'h02;
        cur_nxt.ctl0[`SADC_GO_BIT] = cur_r.ctl0[`SADC_GO_BIT];
        go_wr = 1'b1;
      end
      if (hit(paddr, `SADC_OFF_CTL1)) begin
        cur_nxt.ctl1 = wd & `SADC_MASK_CTL1;
        cur_nxt.strap_pend = 1'b0;
      end
      if (hit(paddr, `SADC_OFF_CTL2)) begin
        cur_nxt.ctl2 = wd & `SADC_MASK_CTL2;
      end
      if (hit(paddr, `SADC_OFF_IRQ)) begin
        cur_nxt.irq_en = wd[`SADC_IEN_BIT];
        if (!wd[`SADC_FLAG_BIT]) begin
          cur_nxt.flag = 1'b0; // cleared by writing zero
        end
      end
    end

    // divider runs only while a sequence is active
    if (cur_r.st == SADC_IDLE || tad_tick) begin
      cur_nxt.divcnt = 6'h00;
    end else begin
      cur_nxt.divcnt = 6'(cur_r.divcnt + 6'h01);
    end

    // sequence
    unique case (cur_r.st)
      SADC_IDLE: begin
        if (go_wr && wd[`SADC_GO_BIT] && wd[`SADC_ON_BIT]) begin
          cur_nxt.ctl0[`SADC_GO_BIT] = 1'b1;
          cur_nxt.divcnt = 6'h00;
          cur_nxt.tadcnt = 5'd0;
          cur_nxt.bitcnt = 4'd9;
          if (rc_sel) begin
            cur_nxt.st = SADC_DELAY;
          end else begin
            // zero or not, the acquisition length is judged in ACQ
            cur_nxt.st = SADC_ACQ;
          end
        end
      end
      SADC_DELAY: begin
        // one instruction cycle counted on pclk before rc clock use
        cur_nxt.divcnt = 6'(cur_r.divcnt + 6'h01);
        if (cur_r.divcnt == 6'(`SADC_TCY_CYC - 6'h01)) begin
          cur_nxt.divcnt = 6'h00;
          cur_nxt.st = SADC_ACQ;
        end
      end
      SADC_ACQ: begin
        // zero programmed time falls straight through
        if (acq_tads(cur_r.ctl2[`SADC_ACQ_MSB:`SADC_ACQ_LSB]) ==
            cur_r.tadcnt) begin
          cur_nxt.st = SADC_CONV;
          cur_nxt.tadcnt = 5'd0;
          cur_nxt.divcnt = 6'h00;
          cur_nxt.sar = 10'h200;
        end else if (tad_tick) begin
          cur_nxt.tadcnt = 5'(cur_r.tadcnt + 5'd1);
        end
      end
      SADC_CONV: begin
        // period 0 holds the sample, periods 1-10 resolve one bit each
        if (tad_tick) begin
          cur_nxt.tadcnt = 5'(cur_r.tadcnt + 5'd1);
          if (cur_r.tadcnt != 5'd0) begin
            cur_nxt.sar = sar_final;
            if (cur_r.bitcnt != 4'd0) begin
              cur_nxt.sar[cur_r.bitcnt - 4'd1] = 1'b1;
              cur_nxt.bitcnt = 4'(cur_r.bitcnt - 4'd1);
            end
          end
          if (cur_r.tadcnt == `SADC_CONV_TADS - 5'd1) begin
            res_load = 1'b1;
            cur_nxt.ctl0[`SADC_GO_BIT] = 1'b0;
            cur_nxt.flag = 1'b1; // set beats a clear
            cur_nxt.tadcnt = 5'd0;
            cur_nxt.st = SADC_HOLD;
          end
        end
      end
      SADC_HOLD: begin
        // go written here waits until the gap has passed
        if (go_wr && wd[`SADC_GO_BIT] && wd[`SADC_ON_BIT]) begin
          cur_nxt.pend = 1'b1;
          cur_nxt.ctl0[`SADC_GO_BIT] = 1'b1;
        end
        if (tad_tick) begin
          cur_nxt.tadcnt = 5'(cur_r.tadcnt + 5'd1);
        end
        if (tad_tick && cur_r.tadcnt == `SADC_HOLD_TADS - 5'd1) begin
          // queued start is read before it is dropped, so a go written
          // on this very edge is not lost with go left stuck at one
          cur_nxt.st = cur_nxt.pend ?
                       (rc_sel ? SADC_DELAY : SADC_ACQ) : SADC_IDLE;
          cur_nxt.tadcnt = 5'd0;
          cur_nxt.pend = 1'b0;
          cur_nxt.bitcnt = 4'd9;
        end
      end
      default: begin
        cur_nxt.st = SADC_IDLE;
      end
    endcase

    // turning off abandons any sequence; clearing go abandons it outside HOLD only
    if (!cur_nxt.ctl0[`SADC_ON_BIT] ||
        (go_wr && !wd[`SADC_GO_BIT] && cur_r.st != SADC_HOLD)) begin
      cur_nxt.st = SADC_IDLE;
      cur_nxt.ctl0[`SADC_GO_BIT] = 1'b0;
      cur_nxt.pend = 1'b0;
      cur_nxt.tadcnt = 5'd0;
      res_load = 1'b0;
      if (cur_r.st == SADC_CONV && tad_tick &&
          cur_r.tadcnt == `SADC_CONV_TADS - 5'd1) begin
        cur_nxt.flag = cur_r.flag; // aborted, no completion
      end
    end

    // read data latched in the setup phase
    if (rd_setup) begin
      cur_nxt.prdata = 32'h0000_0000;
      if (hit(paddr, `SADC_OFF_CTL0)) begin
        cur_nxt.prdata[7:0] = cur_r.ctl0;
      end
      if (hit(paddr, `SADC_OFF_CTL1)) begin
        cur_nxt.prdata[7:0] = cur_r.ctl1;
      end
      if (hit(paddr, `SADC_OFF_CTL2)) begin
        cur_nxt.prdata[7:0] = cur_r.ctl2;
      end
      if (hit(paddr, `SADC_OFF_RESH)) begin
        cur_nxt.prdata[7:0] = result_high_r;
      end
      if (hit(paddr, `SADC_OFF_RESL)) begin
        cur_nxt.prdata[7:0] = result_low_r;
      end
      if (hit(paddr, `SADC_OFF_IRQ)) begin
        cur_nxt.prdata[`SADC_FLAG_BIT] = cur_r.flag;
        cur_nxt.prdata[`SADC_IEN_BIT] = cur_r.irq_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // all control state returns to constants on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r.st <= SADC_IDLE;
      cur_r.ctl0 <= `SADC_RST_CTL;
      cur_r.ctl1 <= `SADC_RST_CTL;
      cur_r.ctl2 <= `SADC_RST_CTL;
      cur_r.flag <= 1'b0;
      cur_r.irq_en <= 1'b0;
      cur_r.strap_pend <= 1'b1;
      cur_r.pend <= 1'b0;
      cur_r.divcnt <= 6'h00;
      cur_r.tadcnt <= 5'd0;
      cur_r.bitcnt <= 4'd9;
      cur_r.sar <= 10'h000;
      cur_r.prdata <= 32'h0000_0000;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // result pair has no reset so it survives a reset as it was
  always_ff @(posedge pclk) begin
    if (res_load) begin
      result_high_r <= res_word[15:8];
      result_low_r <= res_word[7:0];
    end
  end

  // ----------------------------------------------------------------
  // analog front end and interrupt
  // ----------------------------------------------------------------

  // mux, references and pin modes follow the registers directly
  always_comb begin
    analog_ctl.channel = cur_r.ctl0[`SADC_CH_MSB:`SADC_CH_LSB];
    analog_ctl.channel_valid = conv_on &&
      cur_r.ctl0[`SADC_CH_MSB:`SADC_CH_LSB] <= `SADC_LAST_CH;
    analog_ctl.neg_ref_select = cur_r.ctl1[`SADC_NEGREF_BIT];
    analog_ctl.pos_ref_select = cur_r.ctl1[`SADC_POSREF_BIT];
    analog_ctl.analog_mask =
      analog_pins(cur_r.ctl1[`SADC_PCFG_MSB:`SADC_PCFG_LSB]);
    analog_ctl.sample = conv_on && cur_r.st != SADC_CONV;
    analog_ctl.dac_code = cur_r.sar;
  end

  // level request while flag and enable are both set
  assign conversion_irq = cur_r.flag && cur_r.irq_en;

endmodule

// ===== sadc_params.svh
// offsets, field positions, reset values and timing counts of the
// converter control block; included by the package and the module.
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// register byte offsets on the apb bus
`define SADC_OFF_CTL0 12'h000
`define SADC_OFF_CTL1 12'h004
`define SADC_OFF_CTL2 12'h008
`define SADC_OFF_RESH 12'h00c
`define SADC_OFF_RESL 12'h010
`define SADC_OFF_IRQ 12'h014

// control register 0 fields
`define SADC_ON_BIT 0
`define SADC_GO_BIT 1
`define SADC_CH_LSB 2
`define SADC_CH_MSB 5
// control register 1 fields
`define SADC_PCFG_LSB 0
`define SADC_PCFG_MSB 3
`define SADC_POSREF_BIT 4
`define SADC_NEGREF_BIT 5
// control register 2 fields
`define SADC_CS_LSB 0
`define SADC_CS_MSB 2
`define SADC_ACQ_LSB 3
`define SADC_ACQ_MSB 5
`define SADC_FMT_BIT 7
// interrupt register fields
`define SADC_FLAG_BIT 0
`define SADC_IEN_BIT 1

// writable bits of each register; the rest read zero
`define SADC_MASK_CTL0 8'h3f
`define SADC_MASK_CTL1 8'h3f
`define SADC_MASK_CTL2 8'hbf
// reset values
`define SADC_RST_CTL 8'h00
`define SADC_PCFG_STRAP1 4'h0
`define SADC_PCFG_STRAP0 4'h7
`define SADC_LAST_CH 4'hc

// timing
`define SADC_CLK_NS 10
`define SADC_TCY_NS 40
`define SADC_TCY_CYC 6'((`SADC_TCY_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CONV_TADS 5'd11
`define SADC_HOLD_TADS 5'd2
`define SADC_RES_BITS 10

`endif

// ===== sadc_pkg.sv
// types shared by the converter control block.
// assumes sadc_params.svh is on the include path.
`include "sadc_params.svh"

package sadc_pkg;

  // one-hot converter sequence states
  typedef enum logic [4:0] {
    SADC_IDLE = 5'b00001,
    SADC_DELAY = 5'b00010,
    SADC_ACQ = 5'b00100,
    SADC_CONV = 5'b01000,
    SADC_HOLD = 5'b10000
  } sadc_state_e;

  // everything the block drives toward the analog front end
  typedef struct packed {
    logic [3:0] channel;
    logic channel_valid;
    logic neg_ref_select;
    logic pos_ref_select;
    logic [12:0] analog_mask;
    logic sample;
    logic [9:0] dac_code;
  } sadc_analog_s;

  // clocked state of the control block apart from the result pair
  typedef struct packed {
    sadc_state_e st;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic flag;
    logic irq_en;
    logic strap_pend;
    logic pend;
    logic [5:0] divcnt;
    logic [4:0] tadcnt;
    logic [3:0] bitcnt;
    logic [9:0] sar;
    logic [31:0] prdata;
  } sadc_state_s;

endpackage

// ===== sadc_front.sv
// analog front end model: per-channel input levels, a hold capacitor
// and a free-running rc oscillator; assumes pclk and the analog bundle.
module sadc_front
  import sadc_pkg::*;
#(
  parameter int RC_DIV = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sadc_analog_s analog_ctl,
  output logic comparator_high,
  output logic rc_tick
);
  logic [9:0] held_r;
  int rc_cnt;

  // hold capacitor tracks the channel only while sampling is on;
  // every channel pin is treated as an input
  always @(posedge pclk) begin
    if (analog_ctl.sample) begin
      held_r <= 10'h155 + 10'(analog_ctl.channel) * 10'h21;
    end
  end
  assign comparator_high = held_r >= analog_ctl.dac_code;

  // rc oscillator runs free, so the first period may be short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_cnt <= 0;
    end else begin
      rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
    end
  end
  assign rc_tick = rc_cnt == RC_DIV - 1;
endmodule

// ===== sadc_control_chk.sv
// port-level assertions of the converter control block;
// assumes one pclk domain and apb offsets 0x00..0x14.
module sadc_control_chk
  import sadc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sadc_analog_s analog_ctl,
  input wire logic conversion_irq
);
  logic wr;
  logic rd;
  logic irq_wr;

  // access strobes of the apb slave
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign irq_wr = wr && paddr == 12'h014;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // expected analog pin mask for a pin config code
  function automatic logic [12:0] mask_of(logic [3:0] p);
    return (p <= 4'h2) ? 13'h1fff : 13'h1fff >> (p - 4'h2);
  endfunction

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chan_route_a: assert property (
    wr && paddr == 12'h000 |=> analog_ctl.channel == $past(pwdata[5:2]))
    else $error("channel field not routed");
  chan_valid_a: assert property (
    analog_ctl.channel_valid |-> analog_ctl.channel <= 4'hc)
    else $error("unimplemented channel selected");
  conv_off_a: assert property (
    wr && paddr == 12'h000 && !pwdata[0]
      |=> !analog_ctl.sample && !analog_ctl.channel_valid)
    else $error("converter still active when off");
  ref_sel_a: assert property (
    wr && paddr == 12'h004 |=> {analog_ctl.neg_ref_select,
      analog_ctl.pos_ref_select} == $past(pwdata[5:4]))
    else $error("reference select wrong");
  pin_mask_a: assert property (
    wr && paddr == 12'h004
      |=> analog_ctl.analog_mask == mask_of($past(pwdata[3:0])))
    else $error("analog pin mask wrong");
  unimpl_zero_a: assert property (
    rd && paddr <= 12'h008 |-> !prdata[6] && (paddr == 12'h008 || !prdata[7]))
    else $error("unimplemented bit reads one");
  flag_hold_a: assert property (
    conversion_irq && !irq_wr |=> conversion_irq)
    else $error("done interrupt dropped without clear");
  resume_sample_a: assert property (
    $rose(conversion_irq) && !$past(irq_wr) |-> analog_ctl.sample)
    else $error("sampling not resumed at completion");
  bad_addr_a: assert property (
    psel && penable && paddr > 12'h014 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("ready low in access");

  // main scenarios reached
  cover property ($rose(conversion_irq));
  cover property ($fell(analog_ctl.sample));
  cover property (pslverr);
endmodule

bind sadc_control sadc_control_chk chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .analog_ctl,
  .conversion_irq);

// ===== sadc_control_tb.sv
// self-checking bench of the converter control block over apb;
// assumes the front end model supplies comparator and rc ticks.
module sadc_control_tb
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic strap = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic pready, pslverr, rc_tick, comparator_high, conversion_irq, err_q;
  logic [7:0] exp_hi, exp_lo;
  sadc_analog_s actl;
  int n_errors = 0, n_checks = 0, cyc = 0, t_done;

  sadc_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portb_analog_default(strap), .rc_tick(rc_tick),
    .comparator_high(comparator_high), .analog_ctl(actl),
    .conversion_irq(conversion_irq));
  sadc_front #(.RC_DIV(6)) front (.pclk(pclk), .presetn(presetn),
    .analog_ctl(actl), .comparator_high(comparator_high), .rc_tick(rc_tick));

  // 100 MHz clock and a free cycle count for gap timing
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task hang;
    n_errors++;
    stop_test;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge first keeps strobes from double writes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) hang;
    rd_q = prdata; err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  // polls the go bit over at most 200 reads, about 600 cycles
  task wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, 12'h000, 32'h0);
      if (rd_q[1] === 1'b0) break;
    end
    if (i == 200) hang;
  endtask
  // one conversion: a acquisition periods, t cycles a period, x delay,
  // h cycles left idle after it so the next start is not queued
  task conv(input logic [7:0] c2, input logic [3:0] ch, input int a,
      input int t, input int x, input int h);
    int k, e;
    logic [9:0] lv;
    lv = 10'h155 + 10'(ch) * 10'h21;
    e = (a + 11) * t + x;
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h008, {24'h0, c2});
    apb(1'b1, 12'h000, {26'h0, ch, 2'b11});
    for (k = 1; k < 3000; k++) begin
      @(posedge pclk);
      if (conversion_irq === 1'b1) break;
    end
    if (k == 3000) hang;
    t_done = cyc;
    chk((k >= e-t && k <= e+t+3) ? e : k, e);
    {exp_hi, exp_lo} = c2[7] ? {6'h0, lv} : {lv, 6'h0};
    rdc(12'h000, {26'h0, ch, 2'b01});
    rdc(12'h014, 32'h3);
    rdc(12'h00c, 32'(exp_hi));
    rdc(12'h010, 32'(exp_lo));
    repeat (h) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h014, 32'h0);
  endtask
  task t_regs;
    int i;
    logic [12:0] m;
    apb(1'b1, 12'h000, 32'hfc);
    rdc(12'h000, 32'h3c);
    apb(1'b1, 12'h008, 32'hff);
    rdc(12'h008, 32'hbf);
    for (i = 0; i < 16; i++) begin
      apb(1'b1, 12'h004, {24'h0, 2'b11, 2'(i), 4'(i)});
      @(negedge pclk);
      m = (i <= 2) ? 13'h1fff : 13'h1fff >> (i - 2);
      chk(32'(actl.analog_mask), 32'(m));
      chk(32'({actl.neg_ref_select, actl.pos_ref_select}),
        i % 4);
      rdc(12'h004, {26'h0, 2'(i), 4'(i)});
    end
    for (i = 0; i < 16; i++) begin
      apb(1'b1, 12'h000, {26'h0, 4'(i), 2'b01});
      @(negedge pclk);
      chk(32'({actl.channel, actl.channel_valid, actl.sample}),
        32'({4'(i), i < 13, 1'b1}));
    end
    apb(1'b1, 12'h000, 32'h0);
    @(negedge pclk);
    chk(32'({actl.channel_valid, actl.sample}), 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(32'({err_q, rd_q[7:0]}), 32'h100);
  endtask
  task t_convs;
    int acq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int dv [8] = '{2, 8, 32, 6, 4, 16, 64, 6};
    int i;
    for (i = 0; i < 8; i++)
      conv({i[0], 1'b0, 3'(i), 3'b000}, 4'(i),
        acq[i], 2, 0, 4);
    for (i = 0; i < 8; i++)
      conv({i[1], 4'b0001, 3'(i)}, 4'(i + 5), 2, dv[i],
        (i % 4 == 3) ? 4 : 0, 2 * dv[i]);
  endtask
  // go written during the hold gap must wait out two periods
  task t_b2b;
    int k;
    conv(8'h85, 4'h2, 0, 16, 0, 0);
    apb(1'b1, 12'h000, 32'h0b);
    for (k = 0; k < 100; k++) begin
      @(posedge pclk);
      if (actl.sample === 1'b0) break;
    end
    if (k == 100) hang;
    k = cyc - t_done;
    chk((k >= 32 && k <= 51) ? 32 : k, 32);
    wait_idle;
  endtask
  task t_irq;
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h03);
    wait_idle;
    chk(32'(conversion_irq), 32'h0);
    rdc(12'h014, 32'h1);
    // channel 0, left justified; this pair must survive the later reset
    {exp_hi, exp_lo} = {10'h155, 6'h00};
    rdc(12'h00c, 32'(exp_hi));
    rdc(12'h010, 32'(exp_lo));
    apb(1'b1, 12'h014, 32'h3);
    @(negedge pclk);
    chk(32'(conversion_irq), 32'h1);
    apb(1'b1, 12'h014, 32'h2);
    @(negedge pclk);
    chk(32'(conversion_irq), 32'h0);
    rdc(12'h014, 32'h2);
  endtask
  task t_abort;
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h008, 32'h3e);
    apb(1'b1, 12'h000, 32'h07);
    repeat (50) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h04);
    rdc(12'h000, 32'h04);
    // longer than a whole slow conversion, so a late flag would show
    repeat (2100) @(posedge pclk);
    chk(32'(conversion_irq), 32'h0);
    rdc(12'h00c, 32'(exp_hi));
    apb(1'b1, 12'h000, 32'h07);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    strap <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h07);
    rdc(12'h00c, 32'(exp_hi));
    rdc(12'h010, 32'(exp_lo));
    chk(32'(conversion_irq), 32'h0);
  endtask

  // main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_convs;
    t_b2b;
    t_irq;
    t_abort;
    stop_test;
  end
endmodule
